// ===== rtl/acad_datapath.sv
// Purpose: accumulator abs/add datapath with external access timer
// Assumes: inputs synchronous to ref_clk, Wishbone classic master
// Notes: operations run from a command register, one per cycle
`timescale 1ns/1ps
module acad_datapath
	import acad_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_ready,
	output logic ext_strobe,
	output logic ext_write,
	output logic irq
);
	// ==========================================================
	// Bus slave
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic [31:0] wmask;
	logic req, wr, rd;
	assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
	// Writes land at the edge where the master samples ack
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_reg;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wmask[8*gi +: 8] = {8{wb_sel_i[gi]}};
		end
	endgenerate
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] m,
		input logic [31:0] d);
		merge = (o & ~m) | (d & m);
	endfunction
	// ==========================================================
	// Single-port RAM block lookup
	function automatic logic [2:0] blk_of(input logic [15:0] a);
		blk_of = 3'h0;
		for (int i = 0; i < 5; i++)
			if (a >= BLK_LO[i] && a <= BLK_HI[i])
				blk_of = 3'(i + 1);
	endfunction
	acad_bank_t bank_reg, bank_next;
	logic [2:0] blk_a, blk_b;
	logic [1:0] cost;
	assign blk_a = blk_of(bank_reg.addr_a);
	assign blk_b = blk_of(bank_reg.addr_b);
	// Same block must serialise; different blocks go in parallel
	assign cost = (blk_a != 3'h0 && blk_a == blk_b) ? COST_TWO : COST_ONE;
	// ==========================================================
	// Datapath state
	logic [31:0] acc_reg, acc_next, buf_reg, buf_next;
	logic sxm_reg, sxm_next, ovm_reg, ovm_next;
	logic carry_reg, carry_next, ovf_reg, ovf_next;
	logic rpterr_reg, rpterr_next;
	acad_opcmd_t cmd_reg, cmd_next, wcmd;
	logic [7:0] left_reg, left_next;
	acad_ost_t ost_reg, ost_next;
	logic exec, op_done, rpt_bad;
	logic [31:0] opnd, addb, res;
	logic [32:0] sum;
	logic cin, cout, vflag;
	assign wcmd = acad_opcmd_t'(wb_dat_i);
	assign exec = (ost_reg == O_RUN);
	assign op_done = exec && left_reg <= 8'h01;
	always_comb
	begin
		opnd = {{16{sxm_reg & cmd_reg.operand[15]}}, cmd_reg.operand};
		addb = 32'h0;
		cin = 1'b0;
		sum = 33'h0;
		res = acc_reg;
		cout = carry_reg;
		vflag = 1'b0;
		unique case (cmd_reg.op)
			OP_ABS:
			begin
				res = acc_reg[31] ? 32'(-acc_reg) : acc_reg;
				cout = 1'b0;
				vflag = (acc_reg == ACC_MIN);
			end
			OP_ADD_BUFFER_WITH_CARRY_OP:
			begin
				addb = buf_reg;
				cin = carry_reg;
			end
			OP_ADD_SHORT:
				addb = {24'h0, cmd_reg.operand[7:0]};
			OP_ADD16:
				addb = {cmd_reg.operand, 16'h0};
			default:
				addb = opnd << cmd_reg.shift[3:0];
		endcase
		if (cmd_reg.op != OP_ABS)
		begin
			sum = {1'b0, acc_reg} + {1'b0, addb} + {32'h0, cin};
			res = sum[31:0];
			vflag = (acc_reg[31] == addb[31]) && (res[31] != acc_reg[31]);
			// Shift 16 only ever sets carry, so wide sums chain
			cout = (cmd_reg.op == OP_ADD16) ? (carry_reg | sum[32]) : sum[32];
		end
		if (vflag && ovm_reg)
			res = (cmd_reg.op == OP_ABS || !addb[31]) ? ACC_MAX : ACC_MIN;
	end
	assign rpt_bad = wr && wb_adr_i == A_OPCMD && !exec && wcmd.op != OP_ADD_SHORT
		&& wcmd.repeat_single_op != 8'h00 && wcmd.repeat_single_op < RPT_MIN;
	always_comb
	begin
		acc_next = acc_reg;
		buf_next = buf_reg;
		sxm_next = sxm_reg;
		ovm_next = ovm_reg;
		carry_next = carry_reg;
		ovf_next = ovf_reg;
		rpterr_next = rpterr_reg;
		cmd_next = cmd_reg;
		left_next = left_reg;
		ost_next = ost_reg;
		if (wr && wb_adr_i == A_CTRL && wb_sel_i[0])
		begin
			sxm_next = wb_dat_i[C_SXM];
			ovm_next = wb_dat_i[C_OVM];
			carry_next = wb_dat_i[C_CARRY];
			ovf_next = wb_dat_i[C_OVF];
			rpterr_next = wb_dat_i[C_RPTERR];
		end
		if (wr && wb_adr_i == A_ACC && !exec)
			acc_next = merge(acc_reg, wmask, wb_dat_i);
		if (wr && wb_adr_i == A_BUF)
			buf_next = merge(buf_reg, wmask, wb_dat_i);
		if (wr && wb_adr_i == A_OPCMD && !exec)
		begin
			cmd_next = wcmd;
			ost_next = O_RUN;
			// Short form and too-short counts run once
			if (wcmd.op == OP_ADD_SHORT || wcmd.repeat_single_op < RPT_MIN)
				left_next = 8'h01;
			else
				left_next = wcmd.repeat_single_op;
		end
		if (rpt_bad)
			rpterr_next = 1'b1;
		if (exec)
		begin
			acc_next = res;
			carry_next = cout;
			ovf_next = ovf_next | vflag;
			left_next = 8'(left_reg - 8'h01);
			if (op_done)
				ost_next = O_IDLE;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_reg <= 32'h0;
			buf_reg <= 32'h0;
			sxm_reg <= 1'b0;
			ovm_reg <= 1'b0;
			carry_reg <= 1'b0;
			ovf_reg <= 1'b0;
			rpterr_reg <= 1'b0;
			cmd_reg <= '0;
			left_reg <= 8'h0;
			ost_reg <= O_IDLE;
		end
		else
		begin
			acc_reg <= acc_next;
			buf_reg <= buf_next;
			sxm_reg <= sxm_next;
			ovm_reg <= ovm_next;
			carry_reg <= carry_next;
			ovf_reg <= ovf_next;
			rpterr_reg <= rpterr_next;
			cmd_reg <= cmd_next;
			left_reg <= left_next;
			ost_reg <= ost_next;
		end
	end
	// ==========================================================
	// External access timer
	acad_xst_t xst_reg, xst_next;
	acad_xcmd_t xc;
	logic [7:0] xcnt_reg, xcnt_next, xtgt_reg, xtgt_next, xcyc_reg, xcyc_next;
	logic xwr_reg, xwr_next, lastrd_reg, lastrd_next, xdone;
	assign xc = acad_xcmd_t'(wb_dat_i);
	// Ready low freezes the count, adding one cycle per low cycle
	assign xdone = (xst_reg == X_WAIT) && ext_ready && 8'(xcnt_reg + 8'h01) == xtgt_reg;
	always_comb
	begin
		xst_next = xst_reg;
		xcnt_next = xcnt_reg;
		xtgt_next = xtgt_reg;
		xcyc_next = xcyc_reg;
		xwr_next = xwr_reg;
		lastrd_next = lastrd_reg;
		if (xst_reg == X_IDLE && wr && wb_adr_i == A_XCMD)
		begin
			xst_next = X_WAIT;
			xcnt_next = 8'h0;
			xcyc_next = 8'h0;
			xwr_next = xc.write & ~xc.prog;
			if (xc.prog)
				xtgt_next = 8'(RD_CYC + xc.waits);
			else if (xc.waits != 8'h0)
				xtgt_next = 8'(xc.waits + 8'h01);
			else if (xc.write)
				xtgt_next = (lastrd_reg || xc.next_read) ? WR_TURN_CYC : WR_CYC;
			else
				xtgt_next = RD_CYC;
		end
		if (xst_reg == X_WAIT)
		begin
			xcyc_next = 8'(xcyc_reg + 8'h01);
			if (ext_ready)
				xcnt_next = 8'(xcnt_reg + 8'h01);
			if (xdone)
			begin
				xst_next = X_IDLE;
				lastrd_next = ~xwr_reg;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			xst_reg <= X_IDLE;
			xcnt_reg <= 8'h0;
			xtgt_reg <= 8'h0;
			xcyc_reg <= 8'h0;
			xwr_reg <= 1'b0;
			lastrd_reg <= 1'b0;
		end
		else
		begin
			xst_reg <= xst_next;
			xcnt_reg <= xcnt_next;
			xtgt_reg <= xtgt_next;
			xcyc_reg <= xcyc_next;
			xwr_reg <= xwr_next;
			lastrd_reg <= lastrd_next;
		end
	end
	assign ext_strobe = (xst_reg == X_WAIT);
	assign ext_write = xwr_reg;
	// ==========================================================
	// Interrupts, bank and read path
	logic [3:0] ist_reg, ist_next, mask_reg, mask_next, ev;
	assign ev = {rpt_bad, xdone, exec & vflag, op_done};
	assign irq = |(ist_reg & mask_reg);
	always_comb
	begin
		ack_next = req;
		rdat_next = 32'h0;
		bank_next = bank_reg;
		mask_next = mask_reg;
		// A new event wins over the read that clears
		ist_next = ((rd && wb_adr_i == A_IRQ) ? 4'h0 : ist_reg) | ev;
		if (wr && wb_adr_i == A_BANK)
			bank_next = acad_bank_t'(merge(bank_reg, wmask, wb_dat_i));
		if (wr && wb_adr_i == A_MASK && wb_sel_i[0])
			mask_next = wb_dat_i[3:0];
		if (req && !wb_we_i)
			unique case (wb_adr_i)
				A_CTRL: rdat_next = {27'h0, rpterr_reg, ovf_reg, carry_reg, ovm_reg, sxm_reg};
				A_ACC: rdat_next = acc_reg;
				A_BUF: rdat_next = buf_reg;
				A_OPCMD: rdat_next = cmd_reg;
				A_XSTAT: rdat_next = {12'h0, OP_WORDS, ost_reg, ext_strobe, xtgt_reg, xcyc_reg};
				A_BANK: rdat_next = bank_reg;
				A_BCOST: rdat_next = {24'h0, cost, blk_b, blk_a};
				A_IRQ: rdat_next = {28'h0, ist_reg};
				A_MASK: rdat_next = {28'h0, mask_reg};
				default: rdat_next = 32'h0;
			endcase
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
			bank_reg <= '0;
			ist_reg <= R_IRQ;
			mask_reg <= R_MASK;
		end
		else
		begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			bank_reg <= bank_next;
			ist_reg <= ist_next;
			mask_reg <= mask_next;
		end
	end
	// ==========================================================
	// Checks
	a_abs_carry: assert property (@(posedge ref_clk) disable iff (!resetn)
		exec && cmd_reg.op == OP_ABS |=> !carry_reg)
		else $error("abs left carry set");
	a_abs_neg: assert property (@(posedge ref_clk) disable iff (!resetn)
		exec && cmd_reg.op == OP_ABS && acc_reg[31] && acc_reg != ACC_MIN
		|=> acc_reg == 32'(-$past(acc_reg)))
		else $error("abs result wrong");
	a_add16_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
		exec && cmd_reg.op == OP_ADD16 && carry_reg |=> carry_reg)
		else $error("shift-16 add cleared carry");
	a_ovf_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		exec && vflag |=> ovf_reg && (!$past(ovm_reg) || acc_reg == ACC_MAX || acc_reg == ACC_MIN))
		else $error("overflow not flagged or saturated");
	a_short_once: assert property (@(posedge ref_clk) disable iff (!resetn)
		!exec ##1 exec && cmd_reg.op == OP_ADD_SHORT |=> ost_reg == O_IDLE)
		else $error("short add repeated");
	a_read_len: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(ext_strobe) && !ext_write && xtgt_reg == RD_CYC && ext_ready |-> xdone)
		else $error("plain read not one cycle");
	a_write_min: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(ext_strobe) && ext_write |-> !xdone ##1 (xtgt_reg != WR_TURN_CYC || !xdone))
		else $error("external write too short");
	a_wait_total: assert property (@(posedge ref_clk) disable iff (!resetn)
		xdone |-> 8'(xcyc_reg + 8'h01) >= xtgt_reg)
		else $error("external access ended early");
	a_bank_cost: assert property (@(posedge ref_clk) disable iff (!resetn)
		blk_a != 3'h0 && blk_a != blk_b |-> cost == COST_ONE)
		else $error("parallel blocks serialised");
	a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		op_done && mask_reg[I_OP] |=> irq)
		else $error("interrupt missing");
endmodule

// ===== rtl/acad_pkg.sv
// Purpose: constants, types and register map of the accumulator datapath
// Assumes: one 200 MHz clock, classic Wishbone slave with 32-bit data
// Notes: accumulator and buffer are 32 bits, operands 16 bits
// ==========================================================
// What this block does
// - External reads take at least one cycle, external writes at least two.
// - A write directly after or before an external read takes three cycles.
// - With m generator wait states and ready high, reads and writes take m+1.
// - Ready held low for m cycles gives reads m+1 and writes m+2 cycles.
// - Program memory accesses are stretched by p wait cycles.
// - Single-port RAM is split into contiguous 1K or 2K word blocks.
// - One access per block per cycle; different blocks run in parallel.
// - Repeat count must exceed 2 and equals the number of executions.
// - Add shifts the memory or immediate operand left and accumulates it.
// - Vacated low bits of the shifted add operand are zero.
// - High operand bits sign-extend when sign_extend_mode is 1, else zero.
// - Short immediate add ignores sign extension and cannot be repeated.
// - Add with shift 16 sets carry on carry out, else keeps it.
// - Add occupies one program word in direct, indirect and short forms.
package acad_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_ACC = 8'h04;
	localparam logic [7:0] A_BUF = 8'h08;
	localparam logic [7:0] A_OPCMD = 8'h0C;
	localparam logic [7:0] A_XCMD = 8'h10;
	localparam logic [7:0] A_XSTAT = 8'h14;
	localparam logic [7:0] A_BANK = 8'h18;
	localparam logic [7:0] A_BCOST = 8'h1C;
	localparam logic [7:0] A_IRQ = 8'h20;
	localparam logic [7:0] A_MASK = 8'h24;
	localparam int C_SXM = 0;
	localparam int C_OVM = 1;
	localparam int C_CARRY = 2;
	localparam int C_OVF = 3;
	localparam int C_RPTERR = 4;
	localparam int I_OP = 0;
	localparam int I_OVF = 1;
	localparam int I_X = 2;
	localparam int I_RPT = 3;
	localparam logic [3:0] R_IRQ = 4'h0;
	localparam logic [3:0] R_MASK = 4'h0;
	// ==========================================================
	// Arithmetic and timing
	localparam logic [31:0] ACC_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] ACC_MIN = 32'h80000000;
	localparam logic [7:0] RPT_MIN = 8'h03;
	localparam logic [7:0] RD_CYC = 8'h01;
	localparam logic [7:0] WR_CYC = 8'h02;
	localparam logic [7:0] WR_TURN_CYC = 8'h03;
	localparam logic [1:0] OP_WORDS = 2'h1;
	localparam logic [1:0] COST_ONE = 2'h1;
	localparam logic [1:0] COST_TWO = 2'h2;
	localparam logic [4:0][15:0] BLK_LO = {16'h2800, 16'h2000, 16'h1800, 16'h1000, 16'h0800};
	localparam logic [4:0][15:0] BLK_HI = {16'h2BFF, 16'h27FF, 16'h1FFF, 16'h17FF, 16'h0FFF};
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		OP_ABS = 3'h0,
		OP_ADD_BUFFER_WITH_CARRY_OP = 3'h1,
		OP_ADD_DM = 3'h2,
		OP_ADD_SHORT = 3'h3,
		OP_ADD_LONG = 3'h4,
		OP_ADD16 = 3'h5
	} acad_op_t;
	typedef struct packed {
		logic [7:0] repeat_single_op;
		logic [15:0] operand;
		logic [4:0] shift;
		acad_op_t op;
	} acad_opcmd_t;
	typedef struct packed {
		logic [20:0] pad;
		logic next_read;
		logic prog;
		logic [7:0] waits;
		logic write;
	} acad_xcmd_t;
	typedef struct packed {
		logic [15:0] addr_b;
		logic [15:0] addr_a;
	} acad_bank_t;
	typedef enum logic [1:0] {X_IDLE = 2'b00, X_WAIT = 2'b01} acad_xst_t;
	typedef enum logic {O_IDLE = 1'b0, O_RUN = 1'b1} acad_ost_t;
endpackage

// ===== verification/acad_datapath_bench.sv
// Purpose: self-checking bench for the accumulator datapath
// Assumes: classic Wishbone master, 200 MHz clock
// Notes: expectations come from the arithmetic and access timing rules
`timescale 1ns/1ps
module acad_datapath_bench;
	import acad_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, dat_o, q;
	logic ack, ext_ready, ext_strobe, ext_write, irq;
	logic [3:0] stall = 4'h0;
	int bad_count = 0;
	int cmp_count = 0;
	always #2.5 ref_clk = ~ref_clk;
	acad_datapath acad_datapath_i (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .ext_ready(ext_ready), .ext_strobe(ext_strobe),
		.ext_write(ext_write), .irq(irq));
	acad_ext_mem acad_ext_mem_i (.ref_clk(ref_clk), .resetn(resetn), .ext_strobe(ext_strobe),
		.stall(stall), .ext_ready(ext_ready));
	// ==========================================================
	// Bus and compare tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		// Read right after the edge, so these are the values the edge sampled
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (ack !== 1'b1 && k < 50);
		if (k >= 50)
			bad_count++;
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Launch an operation and wait until it is no longer busy
	task automatic op(input acad_op_t o, input logic [4:0] s, input logic [15:0] v,
		input logic [7:0] n);
		int k;
		k = 0;
		wr(A_OPCMD, {n, v, s, o});
		do
		begin
			bus(1'b0, A_XSTAT, 32'h0);
			k++;
		end
		while (q[17] !== 1'b0 && k < 20);
		if (k >= 20)
			bad_count++;
	endtask
	task automatic calc(input logic [31:0] c, input logic [31:0] a, input acad_op_t o,
		input logic [4:0] s, input logic [15:0] v, input logic [31:0] ea, input logic [31:0] ec);
		wr(A_CTRL, c);
		wr(A_ACC, a);
		op(o, s, v, 8'h00);
		rd(A_ACC, ea);
		rd(A_CTRL, ec);
	endtask
	// Timed external access: count strobe cycles, then compare the status
	task automatic xa(input logic w, input logic [7:0] m, input logic pg, input logic nr,
		input logic [3:0] st, input logic [7:0] t, input logic [7:0] e);
		int n;
		n = 0;
		stall <= st;
		wr(A_XCMD, {21'h0, nr, pg, m, w});
		repeat (40)
		begin
			@(posedge ref_clk);
			if (ext_strobe === 1'b1)
				n++;
		end
		chk(32'(n), {24'h0, e});
		chk({31'h0, ext_write}, {31'h0, w & ~pg});
		rd(A_XSTAT, {12'h0, 2'h1, 2'h0, t, e});
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		close_out;
	end
	// ==========================================================
	// Test sequence
	initial
	begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(A_CTRL, 32'h0);
		rd(A_ACC, 32'h0);
		rd(A_MASK, 32'h0);
		rd(A_IRQ, 32'h0);
		rd(8'h30, 32'h0);
		wr(8'h30, 32'h5);
		rd(8'h30, 32'h0);
		$display("test reset done");
		calc(32'h4, 32'hFFFFFFFF, OP_ABS, 5'h0, 16'h0, 32'h1, 32'h0);
		calc(32'h0, 32'h1234, OP_ABS, 5'h0, 16'h0, 32'h1234, 32'h0);
		calc(32'h0, ACC_MIN, OP_ABS, 5'h0, 16'h0, ACC_MIN, 32'h8);
		calc(32'h2, ACC_MIN, OP_ABS, 5'h0, 16'h0, ACC_MAX, 32'hA);
		$display("test abs done");
		wr(A_BUF, 32'h2);
		calc(32'h4, 32'h1234, OP_ADD_BUFFER_WITH_CARRY_OP, 5'h0, 16'h0, 32'h1237, 32'h0);
		wr(A_BUF, 32'h1);
		calc(32'h0, 32'hFFFFFFFF, OP_ADD_BUFFER_WITH_CARRY_OP, 5'h0, 16'h0, 32'h0, 32'h4);
		$display("test add_buffer_with_carry_op done");
		calc(32'h1, 32'h0, OP_ADD_DM, 5'h4, 16'h8000, 32'hFFF80000, 32'h1);
		calc(32'h0, 32'h0, OP_ADD_DM, 5'h4, 16'h8000, 32'h00080000, 32'h0);
		calc(32'h0, 32'h2, OP_ADD_LONG, 5'h1, 16'h1111, 32'h2224, 32'h0);
		calc(32'h1, 32'h3, OP_ADD_SHORT, 5'h0, 16'hFF80, 32'h83, 32'h1);
		calc(32'h2, ACC_MAX, OP_ADD_DM, 5'h0, 16'h1, ACC_MAX, 32'hA);
		calc(32'h0, 32'hFFFF0000, OP_ADD16, 5'h0, 16'h1, 32'h0, 32'h4);
		calc(32'h4, 32'h0, OP_ADD16, 5'h0, 16'h1, 32'h00010000, 32'h4);
		$display("test add done");
		wr(A_CTRL, 32'h0);
		wr(A_ACC, 32'h0);
		op(OP_ADD_DM, 5'h0, 16'h1, 8'h03);
		rd(A_ACC, 32'h3);
		rd(A_CTRL, 32'h0);
		op(OP_ADD_DM, 5'h0, 16'h1, 8'h02);
		rd(A_ACC, 32'h4);
		rd(A_CTRL, 32'h10);
		op(OP_ADD_SHORT, 5'h0, 16'h1, 8'h05);
		rd(A_ACC, 32'h5);
		$display("test repeat done");
		xa(1'b0, 8'h0, 1'b0, 1'b0, 4'h0, 8'h1, 8'h1);
		xa(1'b1, 8'h0, 1'b0, 1'b0, 4'h0, 8'h3, 8'h3);
		xa(1'b1, 8'h0, 1'b0, 1'b0, 4'h0, 8'h2, 8'h2);
		xa(1'b1, 8'h0, 1'b0, 1'b0, 4'h2, 8'h2, 8'h4);
		xa(1'b1, 8'h0, 1'b0, 1'b1, 4'h0, 8'h3, 8'h3);
		xa(1'b0, 8'h3, 1'b0, 1'b0, 4'h0, 8'h4, 8'h4);
		xa(1'b1, 8'h3, 1'b0, 1'b0, 4'h0, 8'h4, 8'h4);
		xa(1'b0, 8'h2, 1'b1, 1'b0, 4'h0, 8'h3, 8'h3);
		xa(1'b0, 8'h0, 1'b0, 1'b0, 4'h2, 8'h1, 8'h3);
		$display("test external done");
		wr(A_BANK, 32'h2BFF2800);
		rd(A_BCOST, 32'hAD);
		wr(A_BANK, 32'h10000800);
		rd(A_BCOST, 32'h51);
		wr(A_BANK, 32'h04000400);
		rd(A_BCOST, 32'h40);
		$display("test blocks done");
		bus(1'b0, A_IRQ, 32'h0);
		wr(A_MASK, 32'h1);
		op(OP_ABS, 5'h0, 16'h0, 8'h00);
		chk({31'h0, irq}, 32'h1);
		rd(A_IRQ, 32'h1);
		// The clear lands at the edge that ended the read
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		wr(A_MASK, 32'h0);
		op(OP_ABS, 5'h0, 16'h0, 8'h00);
		chk({31'h0, irq}, 32'h0);
		rd(A_IRQ, 32'h1);
		$display("test interrupt done");
		close_out;
	end
endmodule

// ===== verification/acad_ext_mem.sv
// Purpose: external memory model that drives the ready line
// Assumes: ready is sampled by the datapath in every strobe cycle
// Notes: the bench sets the stall count before each access
`timescale 1ns/1ps
module acad_ext_mem
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ext_strobe,
	input wire logic [3:0] stall,
	output logic ext_ready
);
	// ==========================================================
	// Ready held low for the first stall cycles of an access
	logic [3:0] cnt_reg;
	assign ext_ready = !(ext_strobe && (cnt_reg < stall));
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			cnt_reg <= 4'h0;
		else if (!ext_strobe)
			cnt_reg <= 4'h0;
		else if (!ext_ready)
			cnt_reg <= cnt_reg + 4'h1;
	end
endmodule
